// ==== common/tz_defines.svh ====
// register offsets, field positions and reset values of the timer block
`ifndef TZ_DEFINES_SVH
`define TZ_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define TZ_ADDR_W          12
`define TZ_OFS_COUNT_LOW   12'hfd2
`define TZ_OFS_PERIOD_HIGH 12'hfd3
`define TZ_OFS_CTRL_A      12'hfd4
`define TZ_OFS_CTRL_B      12'hfd5
`define TZ_OFS_IRQ         12'hfd6

// ****************************************
// ctrl_reg_a fields
// ****************************************
`define TZ_A_TIMER_ON      7
`define TZ_A_OUT_STATUS    5
`define TZ_A_WIDE_MODE     4
`define TZ_A_POST_HI       3
`define TZ_A_POST_LO       0

// ****************************************
// ctrl_reg_b fields
// ****************************************
`define TZ_B_SRC_HI        7
`define TZ_B_SRC_LO        5
`define TZ_B_ASYNC         4
`define TZ_B_PRE_HI        3
`define TZ_B_PRE_LO        0

// ****************************************
// irq register fields
// ****************************************
`define TZ_I_FLAG          0
`define TZ_I_ENABLE        1

// ****************************************
// reset values
// ****************************************
`define TZ_RST_BYTE        8'h00
`define TZ_RST_PRE         15'h0000
`define TZ_RST_POST        4'h0

// ****************************************
// clock source codes
// ****************************************
`define TZ_SRC_PIN         3'h0
`define TZ_SRC_PIN_INV     3'h1
`define TZ_SRC_INSTR       3'h2
`define TZ_SRC_HFO         3'h3
`define TZ_SRC_LFO         3'h4
`define TZ_SRC_SECONDARY_OSC        3'h5
`define TZ_SRC_MFO         3'h6
`define TZ_SRC_LCO         3'h7

`endif

// ==== common/tz_pkg.sv ====
// types shared by the timer block
`include "tz_defines.svh"

package tz_pkg;
    typedef logic [7:0] tz_byte_t;
    typedef logic [3:0] tz_sel_t;
    typedef enum logic [2:0] {
        TZ_PIN     = `TZ_SRC_PIN,
        TZ_PIN_INV = `TZ_SRC_PIN_INV,
        TZ_INSTR   = `TZ_SRC_INSTR,
        TZ_HFO     = `TZ_SRC_HFO,
        TZ_LFO     = `TZ_SRC_LFO,
        TZ_SECONDARY_OSC    = `TZ_SRC_SECONDARY_OSC,
        TZ_MFO     = `TZ_SRC_MFO,
        TZ_LCO     = `TZ_SRC_LCO
    } tz_src_t;
endpackage : tz_pkg

// ==== logic/tz_prescale.sv ====
// power-of-two input prescaler of the timer
`timescale 1ns/1ps
`include "tz_defines.svh"

module tz_prescale (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic          ce,
    // control
    input  wire logic          clr,
    input  wire tz_pkg::tz_sel_t sel,
    // events
    input  wire logic          evt_in,
    output logic               evt_out
);
    logic [14:0] cnt_ff;
    logic [14:0] term;

    // terminal count is two to the sel, minus one
    assign term    = ~(15'h7fff << sel);
    assign evt_out = evt_in & (cnt_ff == term);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= `TZ_RST_PRE;
        end else if (ce) begin
            if (clr) begin
                cnt_ff <= `TZ_RST_PRE;
            end else if (evt_in) begin
                cnt_ff <= (cnt_ff == term) ? `TZ_RST_PRE : cnt_ff + 15'h0001;
            end
        end
    end
endmodule : tz_prescale

// ==== logic/tz_postscale.sv ====
// 1:1 to 1:16 output postscaler of the timer
`timescale 1ns/1ps
`include "tz_defines.svh"

module tz_postscale (
    // clock and reset
    input  wire logic            clock,
    input  wire logic            rst_n,
    input  wire logic            ce,
    // control
    input  wire logic            clr,
    input  wire tz_pkg::tz_sel_t sel,
    // events
    input  wire logic            evt_in,
    output logic                 evt_out
);
    logic [3:0] cnt_ff;

    assign evt_out = evt_in & (cnt_ff == sel);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= `TZ_RST_POST;
        end else if (ce) begin
            if (clr) begin
                cnt_ff <= `TZ_RST_POST;
            end else if (evt_in) begin
                cnt_ff <= (cnt_ff == sel) ? `TZ_RST_POST : cnt_ff + 4'h1;
            end
        end
    end
endmodule : tz_postscale

// ==== logic/tz_timer.sv ====
// 8/16-bit timer with prescaler, postscaler, toggling output and interrupt flag
`timescale 1ns/1ps
`include "tz_defines.svh"

module tz_timer (
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    // register port
    input  wire logic [`TZ_ADDR_W-1:0]   addr,
    input  wire tz_pkg::tz_byte_t        wdata,
    input  wire logic                    wr_stb,
    input  wire logic                    rd_stb,
    output tz_pkg::tz_byte_t             rdata,
    // count clock sources
    input  wire logic                    instr_tick,
    input  wire logic                    ext_clk_pin,
    input  wire logic                    high_freq_osc,
    input  wire logic                    low_freq_osc,
    input  wire logic                    secondary_osc,
    input  wire logic                    mid_freq_osc,
    input  wire logic                    logic_cell_out,
    // power state
    input  wire logic                    sleep,
    // outputs
    output logic                         tick_out,
    output logic                         irq_req,
    output logic                         wake_req
);

    // ****************************************
    // registers
    // ****************************************
    tz_pkg::tz_byte_t count_low_ff;
    tz_pkg::tz_byte_t count_high_ff;
    tz_pkg::tz_byte_t period_high_ff;
    tz_pkg::tz_byte_t cmp_buf_ff;
    tz_pkg::tz_byte_t rdata_ff;
    logic             timer_on_ff;
    logic             wide_mode_ff;
    tz_pkg::tz_sel_t  postscale_ff;
    tz_pkg::tz_src_t  clk_src_ff;
    logic             async_ff;
    tz_pkg::tz_sel_t  prescale_ff;
    logic             irq_flag_ff;
    logic             irq_enable_ff;
    logic             tick_ff;
    logic             pend_ff;
    logic             lvl_prev_ff;
    logic [5:0]       sync1_ff;
    logic [5:0]       sync2_ff;

    // ****************************************
    // decode
    // ****************************************
    logic             wr_q;
    logic             rd_q;
    logic             wr_low;
    logic             wr_high;
    logic             wr_ca;
    logic             wr_cb;
    logic             wr_irq;
    logic             rd_low;
    logic             scaler_clr;

    assign wr_q       = wr_stb & ce;
    assign rd_q       = rd_stb & ce;
    assign wr_low     = wr_q & (addr == `TZ_OFS_COUNT_LOW);
    assign wr_high    = wr_q & (addr == `TZ_OFS_PERIOD_HIGH);
    assign wr_ca      = wr_q & (addr == `TZ_OFS_CTRL_A);
    assign wr_cb      = wr_q & (addr == `TZ_OFS_CTRL_B);
    assign wr_irq     = wr_q & (addr == `TZ_OFS_IRQ);
    assign rd_low     = rd_q & (addr == `TZ_OFS_COUNT_LOW);
    assign scaler_clr = wr_low | wr_ca | wr_cb;

    // ****************************************
    // source synchronisers
    // ****************************************
    logic [5:0] src_raw;

    assign src_raw = {logic_cell_out, mid_freq_osc, secondary_osc,
                      low_freq_osc, high_freq_osc, ext_clk_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                end else if (ce) begin
                    sync1_ff[gi] <= src_raw[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate

    // ****************************************
    // source select and edge detect
    // ****************************************
    logic sel_lvl;
    logic raw_edge;
    logic run;

    always_comb begin
        case (clk_src_ff)
            tz_pkg::TZ_PIN:     sel_lvl = sync2_ff[0];
            tz_pkg::TZ_PIN_INV: sel_lvl = ~sync2_ff[0];
            tz_pkg::TZ_HFO:     sel_lvl = sync2_ff[1];
            tz_pkg::TZ_LFO:     sel_lvl = sync2_ff[2];
            tz_pkg::TZ_SECONDARY_OSC:    sel_lvl = sync2_ff[3];
            tz_pkg::TZ_MFO:     sel_lvl = sync2_ff[4];
            tz_pkg::TZ_LCO:     sel_lvl = sync2_ff[5];
            default:            sel_lvl = 1'b0;
        endcase
    end

    assign raw_edge = (clk_src_ff == tz_pkg::TZ_INSTR) ? instr_tick
                                                        : (sel_lvl & ~lvl_prev_ff);
    // system clock gone in sync sleep; async keeps going
    assign run = ce & timer_on_ff & (async_ff | ~sleep);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lvl_prev_ff <= 1'b0;
        end else if (ce) begin
            lvl_prev_ff <= sel_lvl;
        end
    end

    // ****************************************
    // prescaler and pacing
    // ****************************************
    logic pre_out;
    logic cnt_evt;

    tz_prescale u_pre (
        .clock   (clock),
        .rst_n   (rst_n),
        .ce      (ce),
        .clr     (scaler_clr),
        .sel     (prescale_ff),
        .evt_in  (run & raw_edge),
        .evt_out (pre_out)
    );

    // sync mode holds an edge until the next instruction tick
    assign cnt_evt = async_ff ? (run & pre_out)
                              : (run & instr_tick & (pend_ff | pre_out));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= 1'b0;
        end else if (ce) begin
            if (scaler_clr || !run || async_ff) begin
                pend_ff <= 1'b0;
            end else if (instr_tick) begin
                pend_ff <= 1'b0;
            end else if (pre_out) begin
                pend_ff <= 1'b1;
            end
        end
    end

    // ****************************************
    // counter
    // ****************************************
    logic match8;
    logic roll16;
    logic period_evt;

    assign match8     = cnt_evt & ~wide_mode_ff & (count_low_ff == cmp_buf_ff);
    assign roll16     = cnt_evt & wide_mode_ff & ({count_high_ff, count_low_ff} == 16'hffff);
    assign period_evt = (match8 | roll16) & ~scaler_clr;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_low_ff <= `TZ_RST_BYTE;
        end else if (wr_low) begin
            count_low_ff <= wdata;
        end else if (match8) begin
            count_low_ff <= `TZ_RST_BYTE;
        end else if (cnt_evt) begin
            count_low_ff <= count_low_ff + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_high_ff <= `TZ_RST_BYTE;
        end else if (wr_low && wide_mode_ff) begin
            count_high_ff <= period_high_ff;
        end else if (cnt_evt && wide_mode_ff && count_low_ff == 8'hff) begin
            count_high_ff <= count_high_ff + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmp_buf_ff <= `TZ_RST_BYTE;
        end else if (match8) begin
            cmp_buf_ff <= period_high_ff;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            period_high_ff <= `TZ_RST_BYTE;
        end else if (wr_high) begin
            period_high_ff <= wdata;
        end else if (rd_low && wide_mode_ff) begin
            period_high_ff <= count_high_ff;
        end
    end

    // ****************************************
    // postscaler, output and flag
    // ****************************************
    logic post_out;

    tz_postscale u_post (
        .clock   (clock),
        .rst_n   (rst_n),
        .ce      (ce),
        .clr     (scaler_clr),
        .sel     (postscale_ff),
        .evt_in  (period_evt),
        .evt_out (post_out)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_ff <= 1'b0;
        end else if (post_out) begin
            tick_ff <= ~tick_ff;
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_flag_ff   <= 1'b0;
            irq_enable_ff <= 1'b0;
        end else begin
            if (post_out) begin
                irq_flag_ff <= 1'b1;
            end else if (wr_irq) begin
                irq_flag_ff <= wdata[`TZ_I_FLAG];
            end
            if (wr_irq) begin
                irq_enable_ff <= wdata[`TZ_I_ENABLE];
            end
        end
    end

    assign tick_out = tick_ff;
    assign irq_req  = irq_flag_ff & irq_enable_ff;
    assign wake_req = irq_req & async_ff & sleep;

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_on_ff  <= 1'b0;
            wide_mode_ff <= 1'b0;
            postscale_ff <= `TZ_RST_POST;
        end else if (wr_ca) begin
            timer_on_ff  <= wdata[`TZ_A_TIMER_ON];
            wide_mode_ff <= wdata[`TZ_A_WIDE_MODE];
            postscale_ff <= wdata[`TZ_A_POST_HI:`TZ_A_POST_LO];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_src_ff  <= tz_pkg::TZ_PIN;
            async_ff    <= 1'b0;
            prescale_ff <= `TZ_RST_POST;
        end else if (wr_cb) begin
            clk_src_ff  <= tz_pkg::tz_src_t'(wdata[`TZ_B_SRC_HI:`TZ_B_SRC_LO]);
            async_ff    <= wdata[`TZ_B_ASYNC];
            prescale_ff <= wdata[`TZ_B_PRE_HI:`TZ_B_PRE_LO];
        end
    end

    // ****************************************
    // read port
    // ****************************************
    tz_pkg::tz_byte_t rd_mux;

    always_comb begin
        rd_mux = `TZ_RST_BYTE;
        case (addr)
            `TZ_OFS_COUNT_LOW:   rd_mux = count_low_ff;
            `TZ_OFS_PERIOD_HIGH: rd_mux = period_high_ff;
            `TZ_OFS_CTRL_A: begin
                rd_mux[`TZ_A_TIMER_ON]              = timer_on_ff;
                rd_mux[`TZ_A_OUT_STATUS]            = tick_ff;
                rd_mux[`TZ_A_WIDE_MODE]             = wide_mode_ff;
                rd_mux[`TZ_A_POST_HI:`TZ_A_POST_LO] = postscale_ff;
            end
            `TZ_OFS_CTRL_B: begin
                rd_mux[`TZ_B_SRC_HI:`TZ_B_SRC_LO] = clk_src_ff;
                rd_mux[`TZ_B_ASYNC]               = async_ff;
                rd_mux[`TZ_B_PRE_HI:`TZ_B_PRE_LO] = prescale_ff;
            end
            `TZ_OFS_IRQ: begin
                rd_mux[`TZ_I_FLAG]   = irq_flag_ff;
                rd_mux[`TZ_I_ENABLE] = irq_enable_ff;
            end
            default:             rd_mux = `TZ_RST_BYTE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= `TZ_RST_BYTE;
        end else if (rd_q) begin
            rdata_ff <= rd_mux;
        end
    end

    assign rdata = rdata_ff;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_match;
        match8 && !wr_low;
    endsequence

    property p_match_clear;
        s_match |=> count_low_ff == 8'h00;
    endproperty
    a_match_clear: assert property (p_match_clear) else $error("count not cleared on match");

    property p_reload;
        s_match |=> cmp_buf_ff == $past(period_high_ff);
    endproperty
    a_reload: assert property (p_reload) else $error("compare buffer not reloaded");

    property p_increment;
        cnt_evt && !match8 && !wr_low |=> count_low_ff == $past(count_low_ff) + 8'h01;
    endproperty
    a_increment: assert property (p_increment) else $error("counter did not advance");

    property p_snapshot;
        rd_low && wide_mode_ff && !wr_high |=> period_high_ff == $past(count_high_ff);
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("high byte not snapshotted");

    property p_wide_write;
        wr_low && wide_mode_ff |=> count_high_ff == $past(period_high_ff) && count_low_ff == $past(wdata);
    endproperty
    a_wide_write: assert property (p_wide_write) else $error("16-bit write not applied");

    property p_rollover;
        roll16 && !wr_low |=> {count_high_ff, count_low_ff} == 16'h0000;
    endproperty
    a_rollover: assert property (p_rollover) else $error("no wrap to zero");

    property p_toggle;
        post_out |=> (tick_out != $past(tick_out)) && irq_flag_ff;
    endproperty
    a_toggle: assert property (p_toggle) else $error("output did not toggle");

    property p_flag;
        post_out |=> irq_flag_ff;
    endproperty
    a_flag: assert property (p_flag) else $error("flag not set on toggle");

    property p_sleep_hold;
        sleep && !async_ff && !wr_q |=> $stable(count_low_ff) && $stable(count_high_ff);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("sync counter ran in sleep");

    property p_off_hold;
        !timer_on_ff && !wr_q |=> $stable(count_low_ff) && !tick_out == !$past(tick_out);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("disabled timer changed");

endmodule : tz_timer

// ==== tb/testbench.sv ====
// self-checking testbench of the timer block
`timescale 1ns/1ps
`include "tz_defines.svh"

module testbench;
    // ****************************************
    // signals
    // ****************************************
    logic                  clock;
    logic                  rst_n;
    logic                  ce;
    logic [`TZ_ADDR_W-1:0] addr;
    tz_pkg::tz_byte_t      wdata;
    logic                  wr_stb;
    logic                  rd_stb;
    tz_pkg::tz_byte_t      rdata;
    logic                  instr_tick;
    logic [7:0]            src;
    logic                  sleep;
    logic                  tick_out;
    logic                  irq_req;
    logic                  wake_req;
    logic                  tick_run;
    logic [1:0]            phase;
    logic [31:0]           tick_cnt;
    logic                  rd_d;
    logic [19:0]           exp_q[$];
    logic [19:0]           note;
    int                    mismatches;
    int                    cmp_count;
    integer                seed;
    logic [31:0]           t0;
    logic [7:0]            per;

    tz_timer uut (
        .clock          (clock),
        .rst_n          (rst_n),
        .ce             (ce),
        .addr           (addr),
        .wdata          (wdata),
        .wr_stb         (wr_stb),
        .rd_stb         (rd_stb),
        .rdata          (rdata),
        .instr_tick     (instr_tick),
        .ext_clk_pin    (src[0]),
        .high_freq_osc  (src[3]),
        .low_freq_osc   (src[4]),
        .secondary_osc  (src[5]),
        .mid_freq_osc   (src[6]),
        .logic_cell_out (src[7]),
        .sleep          (sleep),
        .tick_out       (tick_out),
        .irq_req        (irq_req),
        .wake_req       (wake_req)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ****************************************
    // instruction clock: one pulse every fourth cycle while running
    // ****************************************
    always @(posedge clock) begin
        phase <= phase + 2'h1;
        instr_tick <= tick_run && (phase == 2'h0);
        if (tick_run && (phase == 2'h0)) tick_cnt <= tick_cnt + 32'h1;
        rd_d <= rd_stb;
    end

    // ****************************************
    // read checker: oldest note against the returned data
    // ****************************************
    always @(negedge clock) begin
        if (rd_d) begin
            note = exp_q.pop_front();
            cmp_count++;
            if (rdata !== note[7:0]) begin
                mismatches++;
                $display("MISMATCH rdata at %h expected %h seen %h", note[19:8], note[7:0], rdata);
            end
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        exp_q.push_back({a, e});
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        @(posedge clock);
    endtask : rd

    task automatic wait_toggle();
        logic lvl;
        int   n;
        lvl = tick_out;
        n = 0;
        while (tick_out === lvl && n < 20000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 20000) begin
            mismatches++;
            $display("MISMATCH tick_out expected toggle seen none");
            wrap_up();
        end
    endtask : wait_toggle

    task automatic pulse(input logic [2:0] code);
        if (code == 3'h2) begin
            tick_run <= 1'b1;
            repeat (4) @(posedge clock);
            tick_run <= 1'b0;
            repeat (4) @(posedge clock);
        end else begin
            src[code == 3'h1 ? 0 : code] <= 1'b1;
            repeat (4) @(posedge clock);
            src[code == 3'h1 ? 0 : code] <= 1'b0;
            repeat (4) @(posedge clock);
        end
    endtask : pulse

    task automatic wrap_up();
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = 32'h6ce0;
        rst_n = 1'b0;
        ce = 1'b1;
        addr = '0;
        wdata = '0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        src = 8'h00;
        sleep = 1'b0;
        tick_run = 1'b0;
        phase = 2'h0;
        instr_tick = 1'b0;
        tick_cnt = '0;
        rd_d = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        // reset values, unmapped place
        for (int a = 'hfd2; a <= 'hfd7; a++) rd(a[11:0], 8'h00);
        // plain read-back with the timer held off
        per = $random(seed);
        wr(`TZ_OFS_CTRL_B, per);
        rd(`TZ_OFS_CTRL_B, per);
        wr(`TZ_OFS_CTRL_A, per & 8'h1f);
        rd(`TZ_OFS_CTRL_A, per & 8'h1f);
        wr(12'hfd7, 8'h5a);
        rd(12'hfd7, 8'h00);
        // 16-bit coherent transfers
        wr(`TZ_OFS_CTRL_A, 8'h10);
        rd(`TZ_OFS_COUNT_LOW, 8'h00);
        wr(`TZ_OFS_PERIOD_HIGH, 8'h12);
        wr(`TZ_OFS_COUNT_LOW, 8'h34);
        rd(`TZ_OFS_COUNT_LOW, 8'h34);
        rd(`TZ_OFS_PERIOD_HIGH, 8'h12);
        wr(`TZ_OFS_PERIOD_HIGH, 8'h56);
        rd(`TZ_OFS_COUNT_LOW, 8'h34);
        rd(`TZ_OFS_PERIOD_HIGH, 8'h12);
        // every source, asynchronous, 16-bit
        for (int c = 0; c < 8; c++) begin
            wr(`TZ_OFS_CTRL_A, 8'h90);
            wr(`TZ_OFS_CTRL_B, {c[2:0], 5'h10});
            repeat (6) @(posedge clock);
            wr(`TZ_OFS_PERIOD_HIGH, 8'h00);
            wr(`TZ_OFS_COUNT_LOW, 8'h00);
            for (int k = 0; k <= c; k++) pulse(c[2:0]);
            repeat (6) @(posedge clock);
            rd(`TZ_OFS_COUNT_LOW, c[7:0] + 8'h1);
        end
        // prescaler cleared by a count write
        wr(`TZ_OFS_CTRL_B, 8'h13);
        repeat (5) pulse(3'h0);
        wr(`TZ_OFS_COUNT_LOW, 8'h00);
        repeat (7) pulse(3'h0);
        rd(`TZ_OFS_COUNT_LOW, 8'h00);
        pulse(3'h0);
        repeat (6) @(posedge clock);
        rd(`TZ_OFS_COUNT_LOW, 8'h01);
        // a write while the clock enable is low is ignored
        ce <= 1'b0;
        wr(`TZ_OFS_COUNT_LOW, 8'h77);
        ce <= 1'b1;
        rd(`TZ_OFS_COUNT_LOW, 8'h01);
        // 8-bit period, prescaler and postscaler ratios
        wr(`TZ_OFS_IRQ, 8'h02);
        tick_run <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            per = $random(seed) & 8'h03;
            wr(`TZ_OFS_CTRL_A, {4'h8, i[3:0]});
            wr(`TZ_OFS_CTRL_B, {3'h2, 1'b0, 2'h0, 2'(i % 3)});
            wr(`TZ_OFS_PERIOD_HIGH, per);
            wr(`TZ_OFS_COUNT_LOW, 8'h00);
            wait_toggle();
            t0 = tick_cnt;
            wait_toggle();
            chk("period", (per + 1) * (i + 1) * (1 << (i % 3)), tick_cnt - t0);
            chk("irq_req", 1, irq_req);
        end
        wr(`TZ_OFS_CTRL_A, 8'h00);
        rd(`TZ_OFS_CTRL_A, {2'h0, tick_out, 5'h00});
        wr(`TZ_OFS_IRQ, 8'h02);
        rd(`TZ_OFS_IRQ, 8'h02);
        chk("irq_req", 0, irq_req);
        // synchronous pin edges wait for an instruction tick
        wr(`TZ_OFS_CTRL_A, 8'h90);
        wr(`TZ_OFS_CTRL_B, 8'h00);
        wr(`TZ_OFS_COUNT_LOW, 8'h00);
        repeat (3) pulse(3'h0);
        repeat (8) @(posedge clock);
        rd(`TZ_OFS_COUNT_LOW, 8'h03);
        // synchronous sleep halts the count
        wr(`TZ_OFS_CTRL_A, 8'h90);
        wr(`TZ_OFS_CTRL_B, 8'h40);
        sleep <= 1'b1;
        wr(`TZ_OFS_PERIOD_HIGH, 8'h00);
        wr(`TZ_OFS_COUNT_LOW, 8'h40);
        repeat (40) @(posedge clock);
        rd(`TZ_OFS_COUNT_LOW, 8'h40);
        tick_run <= 1'b0;
        // asynchronous sleep keeps counting, rolls over and wakes
        wr(`TZ_OFS_CTRL_B, 8'h10);
        repeat (6) @(posedge clock);
        wr(`TZ_OFS_PERIOD_HIGH, 8'hff);
        wr(`TZ_OFS_COUNT_LOW, 8'hfd);
        wr(`TZ_OFS_IRQ, 8'h02);
        chk("wake_req", 0, wake_req);
        repeat (5) pulse(3'h0);
        repeat (6) @(posedge clock);
        rd(`TZ_OFS_COUNT_LOW, 8'h02);
        rd(`TZ_OFS_PERIOD_HIGH, 8'h00);
        chk("wake_req", 1, wake_req);
        sleep <= 1'b0;
        @(posedge clock);
        @(posedge clock);
        chk("wake_req", 0, wake_req);
        repeat (4) @(posedge clock);
        wrap_up();
    end
endmodule : testbench
